// *** src/mps_sequencer.sv ***
// Purpose: Twelve-bit microprogram address sequencer
// Assumes: All control pins arrive asynchronously and are synchronised
// Notes: Address, enables and full flag are registered outputs
`timescale 1ns/1ns
`include "mps_params.svh"

// Operation
// - Program counter takes address, plus carry
// - Exactly one source enable low
// - Fail only when condition high, enabled
// - Force-load input loads counter from direct
// - Output enable high floats the address
// - Nine-word stack, pointer at top
// - Instruction zero empties stack; empty pop safe
// - Full flag low after ninth net push
// - Jump zero: address zero, clear stack
// - Conditional call pushes return on pass
// - Map jump uses map enable, holds all
// - Conditional jump: direct or program counter
// - Push; conditionally load the counter
// - Vector jump asserts vector enable
// - Loop on direct until counter zero
// - Conditional jump with pop on pass
// - Load counter and continue; plain continue
// - End loop: stack on fail, pop pass
// - Three-way branch on condition and counter
// - All state updates on rising edge
// - Push on full overwrites, pointer stays
// - Preload N gives N plus one passes
module mps_sequencer #(
    parameter int AW = `MPS_ADDR_W,
    parameter int DEPTH = `MPS_STACK_DEPTH
) (
    // Clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Instruction and tests
    input wire mps_pkg::mps_instr_t instr_i,
    input wire logic condition_test_n_i,
    input wire logic condition_test_enable_n_i,
    input wire logic counter_force_load_n_i,
    input wire logic increment_carry_i,
    // Direct input
    input wire logic [AW-1:0] direct_i,
    // Address output, three signals of the bus
    input wire logic address_output_enable_n_i,
    output logic [AW-1:0] next_address_out_o,
    output logic next_address_out_oe_o,
    // Source enables and stack flag
    output logic pipeline_source_enable_n_o,
    output logic map_source_enable_n_o,
    output logic vector_source_enable_n_o,
    output logic stack_full_n_o
);
    import mps_pkg::*;

    localparam int IW = `MPS_F_INSTR + 4;
    localparam int PW = `MPS_SP_W;
    localparam logic [PW-1:0] SP_FULL = PW'(DEPTH);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [IW-1:0] ctl_meta_reg;  // First stage, read only by second
    logic [IW-1:0] ctl_sync_reg;  // Safe control bits
    logic [AW-1:0] din_meta_reg;  // First stage of the direct bus
    logic [AW-1:0] din_sync_reg;  // Safe direct bus
    logic [IW-1:0] ctl_raw;

    assign ctl_raw = {instr_i, condition_test_n_i, condition_test_enable_n_i,
                      counter_force_load_n_i, address_output_enable_n_i,
                      increment_carry_i};

    // Two flops per pin; adds latency but kills metastability
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctl_meta_reg <= `MPS_IN_RST;
            ctl_sync_reg <= `MPS_IN_RST;
            din_meta_reg <= '0;
            din_sync_reg <= '0;
        end
        else if (ce_i)
        begin
            ctl_meta_reg <= ctl_raw;
            ctl_sync_reg <= ctl_meta_reg;
            din_meta_reg <= direct_i;
            din_sync_reg <= din_meta_reg;
        end
    end

    // Named fields of the synchronised word
    mps_instr_t op;
    logic cc_n;
    logic ccen_n;
    logic rld_n;
    logic oe_n;
    logic increment_carry;

    assign op = mps_instr_t'(ctl_sync_reg[`MPS_F_INSTR +: 4]);
    assign cc_n = ctl_sync_reg[`MPS_F_CC_N];
    assign ccen_n = ctl_sync_reg[`MPS_F_CCEN_N];
    assign rld_n = ctl_sync_reg[`MPS_F_RLD_N];
    assign oe_n = ctl_sync_reg[`MPS_F_OE_N];
    assign increment_carry = ctl_sync_reg[`MPS_F_CIN];

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [AW-1:0] pc_reg;      // Microprogram counter
    logic [AW-1:0] pc_next;
    logic [AW-1:0] cnt_reg;     // Register/counter
    logic [AW-1:0] cnt_next;
    logic [PW-1:0] sp_reg;      // Depth, zero when empty
    logic [PW-1:0] sp_next;

    // Stack file link
    mps_stack_if #(.AW(AW), .PW(PW)) sif ();

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Pass unless condition is high with testing enabled
    function automatic logic test_pass(input logic c_n, input logic en_n);
        return !(c_n && !en_n);
    endfunction

    // Table of sources and actions per instruction
    function automatic mps_ctl_t decode(input mps_instr_t i, input logic pass,
                                        input logic zero);
        mps_ctl_t c;
        c = '{src: SRC_PC, stk: STK_HOLD, cnt: CNT_HOLD, en_n: 3'h6};
        unique case (i)
            // Address zero, empty the stack
            jump_zero_reset:
            begin
                c.src = SRC_ZERO;
                c.stk = STK_CLEAR;
            end
            // Call via pipeline
            cond_subroutine_pipeline:
            begin
                c.src = pass ? SRC_DIN : SRC_PC;
                c.stk = pass ? STK_PUSH : STK_HOLD;
            end
            // Map source drives the direct bus
            jump_mapped:
            begin
                c.src = SRC_DIN;
                c.en_n = 3'h5;
            end
            cond_jump_pipeline:
            begin
                c.src = pass ? SRC_DIN : SRC_PC;
            end
            // Loop setup: always push
            push_cond_load:
            begin
                c.stk = STK_PUSH;
                c.cnt = pass ? CNT_LOAD : CNT_HOLD;
            end
            cond_subroutine_reg_or_pipe:
            begin
                c.src = pass ? SRC_DIN : SRC_CNT;
                c.stk = STK_PUSH;
            end
            // Vector source drives the direct bus
            cond_jump_vector:
            begin
                c.src = pass ? SRC_DIN : SRC_PC;
                c.en_n = 3'h3;
            end
            cond_jump_reg_or_pipe:
            begin
                c.src = pass ? SRC_DIN : SRC_CNT;
            end
            // Condition ignored here
            repeat_stack_until_zero:
            begin
                c.src = zero ? SRC_PC : SRC_TOS;
                c.stk = zero ? STK_POP : STK_HOLD;
                c.cnt = zero ? CNT_HOLD : CNT_DEC;
            end
            repeat_pipe_until_zero:
            begin
                c.src = zero ? SRC_PC : SRC_DIN;
                c.cnt = zero ? CNT_HOLD : CNT_DEC;
            end
            cond_return:
            begin
                c.src = pass ? SRC_TOS : SRC_PC;
                c.stk = pass ? STK_POP : STK_HOLD;
            end
            cond_jump_pipe_and_pop:
            begin
                c.src = pass ? SRC_DIN : SRC_PC;
                c.stk = pass ? STK_POP : STK_HOLD;
            end
            load_counter_continue:
            begin
                c.cnt = CNT_LOAD;
            end
            test_end_loop:
            begin
                c.src = pass ? SRC_PC : SRC_TOS;
                c.stk = pass ? STK_POP : STK_HOLD;
            end
            continue_sequential:
            begin
                c.src = SRC_PC;
            end
            // Three-way exit on condition or count
            three_way_branch:
            begin
                c.src = pass ? SRC_PC : (zero ? SRC_DIN : SRC_TOS);
                c.stk = (pass || zero) ? STK_POP : STK_HOLD;
                c.cnt = zero ? CNT_HOLD : CNT_DEC;
            end
        endcase
        return c;
    endfunction

    logic pass;
    logic cnt_zero;
    mps_ctl_t ctl;
    logic [AW-1:0] y_next;

    assign pass = test_pass(cc_n, ccen_n);
    // Zero test sees the value before this edge's decrement
    assign cnt_zero = (cnt_reg == '0);
    assign ctl = decode(op, pass, cnt_zero);

    // ----------------------------------------
    // Next address mux
    // ----------------------------------------
    assign y_next = ({AW{ctl.src[0]}} & '0)
                  | ({AW{ctl.src[1]}} & pc_reg)
                  | ({AW{ctl.src[2]}} & din_sync_reg)
                  | ({AW{ctl.src[3]}} & cnt_reg)
                  | ({AW{ctl.src[4]}} & sif.rd_data);

    // Same word or one more, by the carry
    assign pc_next = y_next + AW'(increment_carry);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Force-load overrides hold and decrement; stop at zero gives N+1
    assign cnt_next = !rld_n ? din_sync_reg
                    : (ctl.cnt == CNT_LOAD) ? din_sync_reg
                    : (ctl.cnt == CNT_DEC) ? cnt_reg - AW'(1)
                    : cnt_reg;

    // ----------------------------------------
    // Stack pointer and file
    // ----------------------------------------
    logic do_push;
    logic sp_full;

    assign do_push = (ctl.stk == STK_PUSH);
    assign sp_full = (sp_reg == SP_FULL);
    // Full push stays put; empty pop stays at zero
    assign sp_next = (ctl.stk == STK_CLEAR) ? `MPS_SP_RST
                   : (do_push && !sp_full) ? sp_reg + PW'(1)
                   : (ctl.stk == STK_POP && sp_reg != '0) ? sp_reg - PW'(1)
                   : sp_reg;

    // Entry k of depth k+1; full push rewrites the top entry
    assign sif.wr_en = do_push;
    assign sif.wr_addr = sp_full ? sp_reg - PW'(1) : sp_reg;
    assign sif.wr_data = pc_reg;
    // Empty stack reads entry zero, contents undefined
    assign sif.rd_addr = (sp_next == '0) ? '0 : sp_next - PW'(1);

    mps_stack_mem #(.DEPTH(DEPTH)) u_stack (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sif(sif)
    );

    // ----------------------------------------
    // Registered state and outputs
    // ----------------------------------------
    // Everything moves on one rising edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pc_reg <= '0;
            cnt_reg <= '0;
            sp_reg <= `MPS_SP_RST;
            next_address_out_o <= '0;
            next_address_out_oe_o <= 1'b0;
            {vector_source_enable_n_o, map_source_enable_n_o,
             pipeline_source_enable_n_o} <= `MPS_EN_RST;
            stack_full_n_o <= 1'b1;
        end
        else if (ce_i)
        begin
            pc_reg <= pc_next;
            cnt_reg <= cnt_next;
            sp_reg <= sp_next;
            next_address_out_o <= y_next;
            next_address_out_oe_o <= !oe_n;
            {vector_source_enable_n_o, map_source_enable_n_o,
             pipeline_source_enable_n_o} <= ctl.en_n;
            stack_full_n_o <= (sp_next != SP_FULL);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_push_at_full;
        ce_i && do_push && sp_full;
    endsequence
    sequence s_ptr_held;
        sp_reg == SP_FULL && !stack_full_n_o;
    endsequence

    property p_pc_load;
        ce_i |=> pc_reg == $past(pc_next) && (pc_reg - next_address_out_o) == AW'($past(increment_carry));
    endproperty
    a_pc_load: assert property (p_pc_load) else $error("pc load wrong");

    property p_one_enable;
        $onehot(~{vector_source_enable_n_o, map_source_enable_n_o,
                  pipeline_source_enable_n_o});
    endproperty
    a_one_enable: assert property (p_one_enable) else $error("enables not one-hot");

    property p_fail_falls;
        ce_i && op == cond_jump_pipeline && cc_n && !ccen_n |=>
            next_address_out_o == $past(pc_reg);
    endproperty
    a_fail_falls: assert property (p_fail_falls) else $error("failed jump taken");

    property p_force_load;
        ce_i && !rld_n |=> cnt_reg == $past(din_sync_reg);
    endproperty
    a_force_load: assert property (p_force_load) else $error("force load lost");

    property p_float;
        ce_i |=>
            next_address_out_oe_o == !$past(oe_n);
    endproperty
    a_float: assert property (p_float) else $error("output enable wrong");

    property p_jump_zero;
        ce_i && op == jump_zero_reset |=> next_address_out_o == '0 && sp_reg == '0
            && !pipeline_source_enable_n_o && stack_full_n_o;
    endproperty
    a_jump_zero: assert property (p_jump_zero) else $error("jump zero wrong");

    property p_full_flag;
        stack_full_n_o == (sp_reg != SP_FULL);
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

    property p_full_push;
        s_push_at_full |=> s_ptr_held;
    endproperty
    a_full_push: assert property (p_full_push) else $error("full push moved pointer");

    property p_repeat_dec;
        ce_i && rld_n && op == repeat_pipe_until_zero && !cnt_zero |=>
            cnt_reg == $past(cnt_reg) - AW'(1) && sp_reg == $past(sp_reg);
    endproperty
    a_repeat_dec: assert property (p_repeat_dec) else $error("counter not decremented");

    property p_map;
        ce_i && op == jump_mapped |=> !map_source_enable_n_o
            && next_address_out_o == $past(din_sync_reg);
    endproperty
    a_map: assert property (p_map) else $error("map jump wrong");
endmodule

// *** src/mps_params.svh ***
// Purpose: Shared constants of the microprogram sequencer
// Assumes: Included by its bare name wherever the values are needed
// Notes: Definitions only, no logic
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH

// ----------------------------------------
// Widths and depths
// ----------------------------------------
`define MPS_ADDR_W 12
`define MPS_STACK_DEPTH 9
`define MPS_SP_W 4

// ----------------------------------------
// Field positions of the sampled input vector
// ----------------------------------------
`define MPS_F_CIN 0
`define MPS_F_OE_N 1
`define MPS_F_RLD_N 2
`define MPS_F_CCEN_N 3
`define MPS_F_CC_N 4
`define MPS_F_INSTR 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPS_IN_RST 9'h00E
`define MPS_SP_RST 4'h0
`define MPS_EN_RST 3'h6

`endif

// *** src/mps_pkg.sv ***
// Purpose: Types of the microprogram sequencer
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes: Codes of the instruction set are fixed by the hardware
package mps_pkg;

    // ----------------------------------------
    // Sequence instructions
    // ----------------------------------------
    typedef enum logic [3:0] {
        jump_zero_reset = 4'h0,
        cond_subroutine_pipeline = 4'h1,
        jump_mapped = 4'h2,
        cond_jump_pipeline = 4'h3,
        push_cond_load = 4'h4,
        cond_subroutine_reg_or_pipe = 4'h5,
        cond_jump_vector = 4'h6,
        cond_jump_reg_or_pipe = 4'h7,
        repeat_stack_until_zero = 4'h8,
        repeat_pipe_until_zero = 4'h9,
        cond_return = 4'hA,
        cond_jump_pipe_and_pop = 4'hB,
        load_counter_continue = 4'hC,
        test_end_loop = 4'hD,
        continue_sequential = 4'hE,
        three_way_branch = 4'hF
    } mps_instr_t;

    // Next address source, one-hot
    typedef enum logic [4:0] {
        SRC_ZERO = 5'h01,
        SRC_PC = 5'h02,
        SRC_DIN = 5'h04,
        SRC_CNT = 5'h08,
        SRC_TOS = 5'h10
    } mps_src_t;

    // Stack action, one-hot
    typedef enum logic [3:0] {
        STK_HOLD = 4'h1,
        STK_PUSH = 4'h2,
        STK_POP = 4'h4,
        STK_CLEAR = 4'h8
    } mps_stk_t;

    // Counter action, one-hot
    typedef enum logic [2:0] {
        CNT_HOLD = 3'h1,
        CNT_LOAD = 3'h2,
        CNT_DEC = 3'h4
    } mps_cnt_t;

    // Active-low enables {vector, map, pipeline}
    typedef logic [2:0] mps_en_t;

    // Decoded control word
    typedef struct packed {
        mps_src_t src;
        mps_stk_t stk;
        mps_cnt_t cnt;
        mps_en_t en_n;
    } mps_ctl_t;

endpackage

// *** src/mps_stack_if.sv ***
// Purpose: Link between the sequencer and its stack file
// Assumes: Single clock domain
// Notes: Read data are registered inside the stack file
`timescale 1ns/1ns
interface mps_stack_if #(parameter int AW = 12, parameter int PW = 4);
    logic wr_en;          // Write strobe
    logic [PW-1:0] wr_addr; // Entry written
    logic [AW-1:0] wr_data; // Word written
    logic [PW-1:0] rd_addr; // Entry that becomes top
    logic [AW-1:0] rd_data; // Registered top word

    modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// *** src/mps_stack_mem.sv ***
// Purpose: Nine-word stack file with a registered top word
// Assumes: rd_addr is the entry that will be on top after this edge
// Notes: A write to that entry is forwarded to the read register
`timescale 1ns/1ns
module mps_stack_mem #(
    parameter int DEPTH = 9
) (
    // Clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Stack port
    mps_stack_if.mem sif
);
    import mps_pkg::*;

    // Storage, no reset needed on contents
    logic [$bits(sif.wr_data)-1:0] mem_reg [DEPTH];
    logic [$bits(sif.wr_data)-1:0] rd_next;
    logic hit;

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Forwarding keeps a fresh push visible on the next cycle
    assign hit = sif.wr_en && (sif.wr_addr == sif.rd_addr);
    assign rd_next = hit ? sif.wr_data : mem_reg[sif.rd_addr];

    // Write port
    always_ff @(posedge clk_i)
    begin
        if (ce_i && sif.wr_en)
        begin
            mem_reg[sif.wr_addr] <= sif.wr_data;
        end
    end

    // Registered read data
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sif.rd_data <= '0;
        end
        else if (ce_i)
        begin
            sif.rd_data <= rd_next;
        end
    end
endmodule

// *** verification/mps_far_model.sv ***
// Purpose: Far side of the sequencer: direct sources and address bus
// Assumes: One clock; each source drives only while enabled
// Notes: A released line shows the inverse of its last value
`timescale 1ns/1ns
module mps_far_model (
    // Clocking
    input wire logic clk_i,
    // Source enables, active low
    input wire logic pipe_n_i,
    input wire logic map_n_i,
    input wire logic vect_n_i,
    // Source words
    input wire logic [11:0] pipe_word_i,
    input wire logic [11:0] map_word_i,
    input wire logic [11:0] vect_word_i,
    // Address pins
    input wire logic [11:0] addr_i,
    input wire logic addr_oe_i,
    // Resolved lines
    output logic [11:0] direct_o,
    output logic [11:0] bus_o
);
    // --------
    // Line resolution
    // --------
    logic [11:0] last_direct; // Direct word one cycle ago
    logic [11:0] last_bus; // Bus word one cycle ago
    // Undriven lines flip, so a stale value never passes for a match
    assign direct_o = !pipe_n_i ? pipe_word_i : !map_n_i ? map_word_i
        : !vect_n_i ? vect_word_i : ~last_direct;
    assign bus_o = addr_oe_i ? addr_i : ~last_bus;
    // Remember both lines each cycle
    always_ff @(posedge clk_i)
    begin
        last_direct <= direct_o;
        last_bus <= bus_o;
    end
endmodule

// *** verification/mps_sequencer_tb.sv ***
// Purpose: Lockstep random check of the microprogram sequencer
// Assumes: Pins act two enabled edges after they are sampled
// Notes: Top of stack is never used while the stack may be empty
`timescale 1ns/1ns
module mps_sequencer_tb;
    import mps_pkg::*;
    // --------
    // Pins
    // --------
    typedef struct packed {
        logic [3:0] ins;
        logic cond_n;
        logic cen_n;
        logic ld_n;
        logic out_en_n;
        logic carry;
        logic [11:0] d;
    } mps_smp_t; // One sampled set of pins
    logic clk_i = 1'b0; // Bench clock
    logic rst_i = 1'b1; // Reset, held at start
    logic ce_i = 1'b1; // Clock enable
    logic [3:0] ins = 4'h0; // Instruction code
    logic cond_n = 1'b0; // Condition, low passes
    logic cond_en_n = 1'b1; // Condition test enable
    logic load_n = 1'b1; // Counter force load
    logic carry = 1'b0; // Increment carry
    logic out_en_n = 1'b1; // Address output enable
    logic [11:0] pw = 12'h000; // Pipeline word
    logic [11:0] mw = 12'h000; // Map word
    logic [11:0] vw = 12'h000; // Vector word
    logic [11:0] direct; // Resolved direct bus
    logic [11:0] addr; // Address pins
    logic [11:0] bus; // Resolved address bus
    logic oe; // Address driven
    logic pipe_n; // Pipeline enable
    logic map_n; // Map enable
    logic vect_n; // Vector enable
    logic full_n; // Stack full flag
    int miscompares = 0; // Mismatches
    int checks = 0; // Comparisons
    // --------
    // Reference state
    // --------
    logic [11:0] pc = 12'h000; // Program counter
    logic [11:0] cnt = 12'h000; // Register/counter
    logic [11:0] y = 12'h000; // Expected address
    logic [11:0] stk [9]; // Stack words
    int dep = 0; // Stack depth
    logic [2:0] en = 3'h6; // Expected enables
    logic oex = 1'b0; // Expected drive
    int ys; // Address source: zero, pc, direct, counter, top
    int act; // Stack: hold, push, pop, clear
    int cop; // Counter: hold, load, decrement
    mps_smp_t q[$]; // Samples inside the synchronisers
    mps_smp_t cur; // Sample taken at the coming edge
    logic ce_q; // Enable at the coming edge
    mps_sequencer u_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .instr_i(mps_instr_t'(ins)),
        .condition_test_n_i(cond_n),
        .condition_test_enable_n_i(cond_en_n),
        .counter_force_load_n_i(load_n),
        .increment_carry_i(carry),
        .direct_i(direct),
        .address_output_enable_n_i(out_en_n),
        .next_address_out_o(addr),
        .next_address_out_oe_o(oe),
        .pipeline_source_enable_n_o(pipe_n),
        .map_source_enable_n_o(map_n),
        .vector_source_enable_n_o(vect_n),
        .stack_full_n_o(full_n)
    );
    mps_far_model u_far (
        .clk_i(clk_i),
        .pipe_n_i(pipe_n),
        .map_n_i(map_n),
        .vect_n_i(vect_n),
        .pipe_word_i(pw),
        .map_word_i(mw),
        .vect_word_i(vw),
        .addr_i(addr),
        .addr_oe_i(oe),
        .direct_o(direct),
        .bus_o(bus)
    );
    // 125 MHz clock
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    // --------
    // Tasks
    // --------
    task pick(input int a, input int b, input int c);
        ys = a;
        act = b;
        cop = c;
    endtask
    // One reference step, in the order the hardware samples
    task exec(input mps_smp_t s);
        logic pass;
        logic z;
        logic [11:0] tos;
        pass = !(s.cond_n && !s.cen_n);
        z = (cnt == 12'h000); // Before any decrement
        tos = stk[(dep > 0) ? dep - 1 : 0];
        case (s.ins)
            4'h0: pick(0, 3, 0);
            4'h1: pick(pass ? 2 : 1, pass ? 1 : 0, 0);
            4'h2: pick(2, 0, 0);
            4'h3: pick(pass ? 2 : 1, 0, 0);
            4'h4: pick(1, 1, pass ? 1 : 0);
            4'h5: pick(pass ? 2 : 3, 1, 0);
            4'h6: pick(pass ? 2 : 1, 0, 0);
            4'h7: pick(pass ? 2 : 3, 0, 0);
            4'h8: pick(z ? 1 : 4, z ? 2 : 0, z ? 0 : 2);
            4'h9: pick(z ? 1 : 2, 0, z ? 0 : 2);
            4'hA: pick(pass ? 4 : 1, pass ? 2 : 0, 0);
            4'hB: pick(pass ? 2 : 1, pass ? 2 : 0, 0);
            4'hC: pick(1, 0, 1);
            4'hD: pick(pass ? 1 : 4, pass ? 2 : 0, 0);
            4'hE: pick(1, 0, 0);
            default: pick(pass ? 1 : (z ? 2 : 4), (pass || z) ? 2 : 0, z ? 0 : 2);
        endcase
        en = (s.ins == 4'h2) ? 3'h5 : (s.ins == 4'h6) ? 3'h3 : 3'h6;
        y = (ys == 0) ? 12'h000 : (ys == 1) ? pc : (ys == 2) ? s.d : (ys == 3) ? cnt : tos;
        if (act == 1)
            stk[(dep < 9) ? dep : 8] = pc; // Full push overwrites top
        if (act == 1 && dep < 9)
            dep = dep + 1;
        if (act == 2 && dep > 0)
            dep = dep - 1; // Empty pop stays at zero
        if (act == 3)
            dep = 0;
        if (!s.ld_n || cop == 1)
            cnt = s.d; // Force load wins
        else if (cop == 2)
            cnt = cnt - 12'h001;
        pc = y + {11'h000, s.carry};
        oex = !s.out_en_n;
    endtask
    // Random pins; directed fill, overflow and loop first
    task drive(input int i);
        logic safe;
        logic [3:0] r;
        safe = dep >= 3 && q[0].ins != 4'h0 && q[1].ins != 4'h0;
        r = 4'($urandom_range(15));
        if (!safe && (r == 4'h8 || r == 4'hA || r == 4'hD || r == 4'hF))
            r = 4'h4; // Top word would be meaningless
        ins <= (i < 14) ? 4'h4 : (i == 14) ? 4'hC : (i < 22) ? 4'h8 : r;
        cond_n <= 1'($urandom_range(1));
        cond_en_n <= (i < 22) | 1'($urandom_range(1));
        load_n <= (i < 22) | ($urandom_range(7) != 0);
        carry <= (i < 22) | 1'($urandom_range(1));
        out_en_n <= ($urandom_range(3) == 0);
        ce_i <= (i < 22) | ($urandom_range(7) != 0);
        pw <= (i < 22) ? 12'h003 : 12'($urandom);
        mw <= 12'($urandom);
        vw <= 12'($urandom);
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // All outputs against the reference
    task compare;
        check({4'h0, addr}, {4'h0, y});
        check({13'h0000, vect_n, map_n, pipe_n}, {13'h0000, en});
        check({15'h0000, full_n}, {15'h0000, dep != 9});
        check({15'h0000, oe}, {15'h0000, oex});
        if (oex)
            check({4'h0, bus}, {4'h0, y});
    endtask
    task report_and_stop;
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // --------
    // Main sequence
    // --------
    initial
    begin
        void'($urandom(33));
        cur = {4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 12'h000}; // Synchroniser reset contents
        q.push_back(cur);
        q.push_back(cur);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        #2;
        compare();
        for (int i = 0; i < 3000; i++)
        begin
            cur = {ins, cond_n, cond_en_n, load_n, out_en_n, carry, direct};
            ce_q = ce_i;
            @(posedge clk_i);
            if (ce_q)
            begin
                exec(q.pop_front());
                q.push_back(cur);
            end
            drive(i);
            #2;
            compare();
            // Mid-run reset, off the edge, then restart the reference
            if (i == 1500)
            begin
                rst_i <= 1'b1;
                repeat (2) @(posedge clk_i);
                rst_i <= 1'b0;
                pc = 12'h000;
                cnt = 12'h000;
                y = 12'h000;
                dep = 0;
                en = 3'h6;
                oex = 1'b0;
                cur = {4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 12'h000};
                q.delete();
                q.push_back(cur);
                q.push_back(cur);
                #2;
                compare();
            end
        end
        report_and_stop();
    end
    // Watchdog, well beyond the 3000 cycles of the run
    initial
    begin
        #40000;
        miscompares++;
        report_and_stop();
    end
endmodule
